// file: inc/zpio_pkg.sv
// Constants and types shared by the zone PLC register block
package zpio_pkg;

  // ------------------------------------------------------------
  // Register offsets (hexadecimal module register numbers)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_STOP_CAUSE    = 8'h13;
  localparam logic [7:0] OFS_SENSOR_INPUTS = 8'h23;
  localparam logic [7:0] OFS_LEFT_SPEED    = 8'h28;
  localparam logic [7:0] OFS_RIGHT_SPEED   = 8'h40;
  localparam logic [7:0] OFS_US_ACCUM      = 8'h68;
  localparam logic [7:0] OFS_US_TRACK_W1   = 8'h84;
  localparam logic [7:0] OFS_US_TRACK_W2   = 8'h85;
  localparam logic [7:0] OFS_DS_ACCUM      = 8'hb8;
  localparam logic [7:0] OFS_DS_TRACK_W1   = 8'hd4;
  localparam logic [7:0] OFS_DS_TRACK_W2   = 8'hd5;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_SEN_LEFT_AUX  = 0;
  localparam int BIT_SEN_RIGHT_AUX = 2;
  localparam int BIT_SEN_LEFT      = 4;
  localparam int BIT_SEN_RIGHT     = 6;
  localparam int BIT_HEARTBEAT     = 15;
  localparam int BIT_STOP_GROUP    = 5;
  localparam int BIT_STOP_COMM     = 6;
  localparam int BIT_STOP_PLC_LOST = 7;
  localparam int BIT_STOP_PLC_CMD  = 10;
  localparam int BIT_ACC_MODE      = 0;
  localparam int BIT_ACC_UPSTREAM  = 8;
  localparam int BIT_ARRIVAL_CONF  = 9;
  localparam int BIT_JOG_FWD       = 10;
  localparam int BIT_JOG_REV       = 11;
  localparam int BIT_WAKE          = 12;
  localparam int BIT_MAINT         = 13;

  // ------------------------------------------------------------
  // Values and timing
  // ------------------------------------------------------------
  localparam logic [15:0] RST_WORD      = 16'h0000;
  localparam logic [15:0] TRACK_KEEP    = 16'h0000;
  localparam logic [15:0] TRACK_CLEAR   = 16'hffff;
  localparam logic [3:0]  WAKE_STATUS   = 4'h4;
  localparam longint      CLK_HZ        = 10000000;
  localparam longint      HEARTBEAT_MS  = 2000;
  localparam longint      HEARTBEAT_CYC = CLK_HZ / 1000 * HEARTBEAT_MS;
  localparam longint      FLASH_MS      = 500;
  localparam longint      FLASH_CYC     = CLK_HZ / 1000 * FLASH_MS;

  typedef enum logic [1:0] {
    ZPIO_Z_IDLE  = 2'b00,
    ZPIO_Z_HOLD  = 2'b01,
    ZPIO_Z_RELS  = 2'b11,
    ZPIO_Z_CONF  = 2'b10
  } zpio_zstate_t;

endpackage : zpio_pkg

// file: inc/zpio_zone_if.sv
// Interface between register bank and one zone's control logic
`timescale 1ns/100ps
interface zpio_zone_if;
  logic [15:0] accum_ctrl;
  logic [15:0] pend_w1;
  logic [15:0] pend_w2;
  logic        release_evt;
  logic        discharge_evt;
  logic        arrival_evt;
  logic        zone_blocked;
  logic [15:0] track_w1;
  logic [15:0] track_w2;
  logic        run;
  logic        jog_rev;
  logic        busy_up;
  logic        accum_up;
  logic        jam;
  logic        flash_green;

  modport bank (
    output accum_ctrl, pend_w1, pend_w2, release_evt, discharge_evt,
           arrival_evt, zone_blocked,
    input  track_w1, track_w2, run, jog_rev, busy_up, accum_up, jam,
           flash_green
  );
  modport zone (
    input  accum_ctrl, pend_w1, pend_w2, release_evt, discharge_evt,
           arrival_evt, zone_blocked,
    output track_w1, track_w2, run, jog_rev, busy_up, accum_up, jam,
           flash_green
  );
endinterface : zpio_zone_if

// file: rtl/zpio_bank.sv
// PLC-facing register bank of a two-zone accumulation controller
`timescale 1ns/100ps

module zpio_bank
#(
  parameter longint HEARTBEAT_CYC = zpio_pkg::HEARTBEAT_CYC,
  parameter longint FLASH_CYC     = zpio_pkg::FLASH_CYC
)
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_wr_en,
  input  wire logic [7:0]  i_wr_addr,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_rd_en,
  input  wire logic [7:0]  i_rd_addr,
  input  wire logic [15:0] i_release_us,
  input  wire logic [15:0] i_release_ds,
  input  wire logic [3:0]  i_sens_raw,
  input  wire logic [3:0]  i_sens_invert,
  input  wire logic        i_stop_group,
  input  wire logic        i_stop_comm_lost,
  input  wire logic        i_stop_plc_lost,
  input  wire logic        i_stop_plc_cmd,
  input  wire logic [1:0]  i_zone_blocked,
  input  wire logic [1:0]  i_discharge,
  input  wire logic [1:0]  i_arrival,
  input  wire logic [1:0]  i_upstream_status_4,
  input  wire logic [15:0] i_cfg_left_speed,
  input  wire logic [15:0] i_cfg_right_speed,
  output logic      [15:0] o_rd_data,
  output logic      [15:0] o_left_speed_ref,
  output logic      [15:0] o_right_speed_ref,
  output logic      [1:0]  o_motor_run,
  output logic      [1:0]  o_motor_rev,
  output logic      [1:0]  o_busy_upstream,
  output logic      [1:0]  o_accum_upstream,
  output logic      [1:0]  o_jam,
  output logic      [1:0]  o_indicator_flash,
  output logic      [15:0] o_us_track_w1,
  output logic      [15:0] o_us_track_w2,
  output logic      [15:0] o_ds_track_w1,
  output logic      [15:0] o_ds_track_w2
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] rd_data;
    logic [31:0] hb_cnt;
    logic        hb;
    logic [31:0] fl_cnt;
    logic        fl;
    logic [15:0] left_raw;
    logic [15:0] right_raw;
    logic [15:0] left_ref;
    logic [15:0] right_ref;
    logic [15:0] us_acc;
    logic [15:0] ds_acc;
    logic [15:0] us_w1;
    logic [15:0] us_w2;
    logic [15:0] ds_w1;
    logic [15:0] ds_w2;
    logic [15:0] rel_us_prev;
    logic [15:0] rel_ds_prev;
    logic [1:0]  rel_pulse;
    logic [1:0]  run;
    logic [1:0]  rev;
    logic [1:0]  busy;
    logic [1:0]  accup;
    logic [1:0]  jam;
    logic [1:0]  flash;
    logic [15:0] us_t1;
    logic [15:0] us_t2;
    logic [15:0] ds_t1;
    logic [15:0] ds_t2;
  } zpio_bank_st_t;

  zpio_bank_st_t s_reg;
  zpio_bank_st_t s_next;

  logic [15:0] sensor_word;
  logic [15:0] stop_word;
  logic [3:0]  sens_blocked;

  zpio_zone_if zi [2] ();

  // ------------------------------------------------------------
  // Zones
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_zone
      assign zi[g].accum_ctrl    = (g == 0) ? s_reg.us_acc : s_reg.ds_acc;
      assign zi[g].pend_w1       = (g == 0) ? s_reg.us_w1 : s_reg.ds_w1;
      assign zi[g].pend_w2       = (g == 0) ? s_reg.us_w2 : s_reg.ds_w2;
      assign zi[g].release_evt   = s_reg.rel_pulse[g];
      assign zi[g].discharge_evt = i_discharge[g];
      assign zi[g].arrival_evt   = i_arrival[g];
      assign zi[g].zone_blocked  = i_zone_blocked[g];
      zpio_zone u_zone
      (
        .i_ref_clk       (i_ref_clk),
        .i_rst           (i_rst),
        .i_flash         (s_reg.fl),
        .i_wake_status_4 (i_upstream_status_4[g]),
        .zif             (zi[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Status words
  // ------------------------------------------------------------
  // Polarity from auto-configuration: blocked reads as 1
  assign sens_blocked = i_sens_raw ^ i_sens_invert;

  always_comb
  begin
    sensor_word = zpio_pkg::RST_WORD;
    sensor_word[zpio_pkg::BIT_SEN_LEFT_AUX]  = sens_blocked[0];
    sensor_word[zpio_pkg::BIT_SEN_RIGHT_AUX] = sens_blocked[1];
    sensor_word[zpio_pkg::BIT_SEN_LEFT]      = sens_blocked[2];
    sensor_word[zpio_pkg::BIT_SEN_RIGHT]     = sens_blocked[3];
    sensor_word[zpio_pkg::BIT_HEARTBEAT]     = s_reg.hb;
    stop_word = zpio_pkg::RST_WORD;
    stop_word[zpio_pkg::BIT_STOP_GROUP]    = i_stop_group;
    stop_word[zpio_pkg::BIT_STOP_COMM]     = i_stop_comm_lost;
    stop_word[zpio_pkg::BIT_STOP_PLC_LOST] = i_stop_plc_lost;
    stop_word[zpio_pkg::BIT_STOP_PLC_CMD]  = i_stop_plc_cmd;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    // Heartbeat: equal high and low phases
    if (s_reg.hb_cnt == 32'(HEARTBEAT_CYC - 1))
    begin
      s_next.hb_cnt = 32'h0000_0000;
      s_next.hb     = ~s_reg.hb;
    end
    else
      s_next.hb_cnt = s_reg.hb_cnt + 32'h0000_0001;
    if (s_reg.fl_cnt == 32'(FLASH_CYC - 1))
    begin
      s_next.fl_cnt = 32'h0000_0000;
      s_next.fl     = ~s_reg.fl;
    end
    else
      s_next.fl_cnt = s_reg.fl_cnt + 32'h0000_0001;

    if (i_wr_en)
    begin
      unique case (i_wr_addr)
        zpio_pkg::OFS_LEFT_SPEED:  s_next.left_raw  = i_wr_data;
        zpio_pkg::OFS_RIGHT_SPEED: s_next.right_raw = i_wr_data;
        zpio_pkg::OFS_US_ACCUM:    s_next.us_acc    = i_wr_data;
        zpio_pkg::OFS_DS_ACCUM:    s_next.ds_acc    = i_wr_data;
        zpio_pkg::OFS_US_TRACK_W1: s_next.us_w1     = i_wr_data;
        zpio_pkg::OFS_US_TRACK_W2: s_next.us_w2     = i_wr_data;
        zpio_pkg::OFS_DS_TRACK_W1: s_next.ds_w1     = i_wr_data;
        zpio_pkg::OFS_DS_TRACK_W2: s_next.ds_w2     = i_wr_data;
        default: ;
      endcase
      // Zero never reaches the motor; last non-zero stays
      if (i_wr_addr == zpio_pkg::OFS_LEFT_SPEED &&
          i_wr_data != zpio_pkg::RST_WORD)
        s_next.left_ref = i_wr_data;
      if (i_wr_addr == zpio_pkg::OFS_RIGHT_SPEED &&
          i_wr_data != zpio_pkg::RST_WORD)
        s_next.right_ref = i_wr_data;
    end

    // Repeated identical images are not events
    s_next.rel_us_prev  = i_release_us;
    s_next.rel_ds_prev  = i_release_ds;
    s_next.rel_pulse[0] = (i_release_us != s_reg.rel_us_prev) &&
                          s_reg.us_acc[zpio_pkg::BIT_ACC_MODE];
    s_next.rel_pulse[1] = (i_release_ds != s_reg.rel_ds_prev) &&
                          s_reg.ds_acc[zpio_pkg::BIT_ACC_MODE];

    s_next.run   = {zi[1].run, zi[0].run};
    s_next.rev   = {zi[1].jog_rev, zi[0].jog_rev};
    s_next.busy  = {zi[1].busy_up, zi[0].busy_up};
    s_next.accup = {zi[1].accum_up, zi[0].accum_up};
    s_next.jam   = {zi[1].jam, zi[0].jam};
    s_next.flash = {zi[1].flash_green, zi[0].flash_green};
    s_next.us_t1 = zi[0].track_w1;
    s_next.us_t2 = zi[0].track_w2;
    s_next.ds_t1 = zi[1].track_w1;
    s_next.ds_t2 = zi[1].track_w2;

    s_next.rd_data = zpio_pkg::RST_WORD;
    if (i_rd_en)
    begin
      unique case (i_rd_addr)
        zpio_pkg::OFS_STOP_CAUSE:    s_next.rd_data = stop_word;
        zpio_pkg::OFS_SENSOR_INPUTS: s_next.rd_data = sensor_word;
        zpio_pkg::OFS_LEFT_SPEED:    s_next.rd_data = s_reg.left_raw;
        zpio_pkg::OFS_RIGHT_SPEED:   s_next.rd_data = s_reg.right_raw;
        zpio_pkg::OFS_US_ACCUM:      s_next.rd_data = s_reg.us_acc;
        zpio_pkg::OFS_DS_ACCUM:      s_next.rd_data = s_reg.ds_acc;
        zpio_pkg::OFS_US_TRACK_W1:   s_next.rd_data = s_reg.us_w1;
        zpio_pkg::OFS_US_TRACK_W2:   s_next.rd_data = s_reg.us_w2;
        zpio_pkg::OFS_DS_TRACK_W1:   s_next.rd_data = s_reg.ds_w1;
        zpio_pkg::OFS_DS_TRACK_W2:   s_next.rd_data = s_reg.ds_w2;
        default:                     s_next.rd_data = zpio_pkg::RST_WORD;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_left_speed_ref  <= zpio_pkg::RST_WORD;
      o_right_speed_ref <= zpio_pkg::RST_WORD;
    end
    else
    begin
      // Configured speed until a non-zero value arrives
      o_left_speed_ref  <= (s_reg.left_ref == zpio_pkg::RST_WORD) ?
                           i_cfg_left_speed : s_reg.left_ref;
      o_right_speed_ref <= (s_reg.right_ref == zpio_pkg::RST_WORD) ?
                           i_cfg_right_speed : s_reg.right_ref;
    end
  end

  assign o_rd_data         = s_reg.rd_data;
  assign o_motor_run       = s_reg.run;
  assign o_motor_rev       = s_reg.rev;
  assign o_busy_upstream   = s_reg.busy;
  assign o_accum_upstream  = s_reg.accup;
  assign o_jam             = s_reg.jam;
  assign o_indicator_flash = s_reg.flash;
  assign o_us_track_w1     = s_reg.us_t1;
  assign o_us_track_w2     = s_reg.us_t2;
  assign o_ds_track_w1     = s_reg.ds_t1;
  assign o_ds_track_w2     = s_reg.ds_t2;

endmodule : zpio_bank

// file: rtl/zpio_zone.sv
// One zone: tracking commit, accumulation, jog, wake and maintenance
`timescale 1ns/100ps
module zpio_zone
(
  input  wire logic    i_ref_clk,
  input  wire logic    i_rst,
  input  wire logic    i_flash,
  input  wire logic    i_wake_status_4,
  zpio_zone_if.zone    zif
);

  typedef struct packed {
    zpio_pkg::zpio_zstate_t st;
    logic [15:0]            trk1;
    logic [15:0]            trk2;
    logic                   run;
    logic                   jog_rev;
    logic                   jam;
  } zpio_zone_st_t;

  zpio_zone_st_t s_reg;
  zpio_zone_st_t s_next;

  logic acc_mode;
  logic jog_f;
  logic jog_r;
  logic wake;
  logic maint;
  logic conf;

  assign acc_mode = zif.accum_ctrl[zpio_pkg::BIT_ACC_MODE];
  assign jog_f    = zif.accum_ctrl[zpio_pkg::BIT_JOG_FWD];
  assign jog_r    = zif.accum_ctrl[zpio_pkg::BIT_JOG_REV];
  assign wake     = zif.accum_ctrl[zpio_pkg::BIT_WAKE];
  assign maint    = zif.accum_ctrl[zpio_pkg::BIT_MAINT];
  assign conf     = zif.accum_ctrl[zpio_pkg::BIT_ARRIVAL_CONF];

  always_comb
  begin
    s_next = s_reg;
    // Commit pending words on release
    if (zif.release_evt)
    begin
      if (zif.pend_w1 == zpio_pkg::TRACK_KEEP &&
          zif.pend_w2 == zpio_pkg::TRACK_KEEP)
      begin
        s_next.trk1 = s_reg.trk1;
      end
      else if (zif.pend_w1 == zpio_pkg::TRACK_CLEAR &&
               zif.pend_w2 == zpio_pkg::TRACK_CLEAR)
      begin
        s_next.trk1 = zpio_pkg::RST_WORD;
        s_next.trk2 = zpio_pkg::RST_WORD;
      end
      else
      begin
        s_next.trk1 = zif.pend_w1;
        s_next.trk2 = zif.pend_w2;
      end
    end
    unique case (s_reg.st)
      zpio_pkg::ZPIO_Z_IDLE:
      begin
        if (zif.zone_blocked && acc_mode)
          s_next.st = zpio_pkg::ZPIO_Z_HOLD;
        else if (zif.zone_blocked)
          s_next.st = zpio_pkg::ZPIO_Z_RELS;
      end
      zpio_pkg::ZPIO_Z_HOLD:
      begin
        if (!acc_mode || zif.release_evt)
          s_next.st = zpio_pkg::ZPIO_Z_RELS;
      end
      zpio_pkg::ZPIO_Z_RELS:
      begin
        if (zif.discharge_evt)
          s_next.st = zpio_pkg::ZPIO_Z_CONF;
      end
      zpio_pkg::ZPIO_Z_CONF:
      begin
        // Jam if zone is blocked again before discharge is confirmed downstream or by PLC
        if (zif.arrival_evt || conf)
        begin
          s_next.st  = zpio_pkg::ZPIO_Z_IDLE;
          s_next.jam = 1'b0;
        end
        else if (zif.zone_blocked)
          s_next.jam = 1'b1;
      end
    endcase
    s_next.run = ((s_reg.st == zpio_pkg::ZPIO_Z_RELS) ||
                  (s_reg.st == zpio_pkg::ZPIO_Z_IDLE &&
                   (wake || i_wake_status_4)));
    if (jog_f || jog_r)
      s_next.run = 1'b1;
    s_next.jog_rev = jog_r && !jog_f;
    if (maint)
      s_next.run = 1'b0;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      s_reg <= '{zpio_pkg::ZPIO_Z_IDLE, 16'h0000, 16'h0000,
                 1'b0, 1'b0, 1'b0};
    else
      s_reg <= s_next;
  end

  assign zif.track_w1    = s_reg.trk1;
  assign zif.track_w2    = s_reg.trk2;
  assign zif.run         = s_reg.run;
  assign zif.jog_rev     = s_reg.jog_rev;
  assign zif.jam         = s_reg.jam;
  assign zif.busy_up     = maint;
  assign zif.accum_up    = zif.accum_ctrl[zpio_pkg::BIT_ACC_UPSTREAM];
  assign zif.flash_green = maint && i_flash;

endmodule : zpio_zone

// file: tb/testbench.sv
// Self-checking bench for the zone PLC register bank
`timescale 1ns/100ps
module testbench;
  localparam logic [15:0] HB = 16'h000a;
  localparam logic [19:0] CT [5] = '{20'h0400_8, 20'h0800_c,
    20'h0100_1, 20'h1000_8, 20'h2400_2};
  localparam logic [7:0] RW [8] = '{8'h28, 8'h40, 8'h68, 8'h84,
    8'h85, 8'hb8, 8'hd4, 8'hd5};

  logic        i_ref_clk = 1'b0;
  logic        i_rst     = 1'b1;
  logic        wr_en, rd_en, hb;
  logic [7:0]  wr_addr, rd_addr;
  logic [15:0] wr_data, rd_data, rel_us, rel_ds, lref, rref;
  logic [15:0] us1, us2, ds1, ds2, cfg_l, cfg_r, d, a, b, v;
  logic [15:0] run_len, toggles;
  logic [3:0]  sraw = 4'h0;
  logic [3:0]  sinv = 4'h0;
  logic [3:0]  stp  = 4'h0;
  logic [1:0]  blk  = 2'b00;
  logic [1:0]  dis  = 2'b00;
  logic [1:0]  arr  = 2'b00;
  logic [1:0]  ups4 = 2'b00;
  logic [1:0]  run, rev, busy, accu, jam, flash;
  logic [15:0] relv [2];
  logic [31:0] cur [2];
  int          err_count = 0;
  int          tests_run = 0;
  int          seed, k, z;

  zpio_plc plc (.i_ref_clk(i_ref_clk), .i_rd_data(rd_data),
    .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
    .o_rd_en(rd_en), .o_rd_addr(rd_addr), .o_rel_us(rel_us),
    .o_rel_ds(rel_ds));

  // Short counts keep heartbeat and flash phases within the run
  zpio_bank #(.HEARTBEAT_CYC(HB), .FLASH_CYC(4)) i_zpio_bank (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wr_en(wr_en),
    .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_rd_en(rd_en),
    .i_rd_addr(rd_addr), .i_release_us(rel_us), .i_release_ds(rel_ds),
    .i_sens_raw(sraw), .i_sens_invert(sinv), .i_stop_group(stp[0]),
    .i_stop_comm_lost(stp[1]), .i_stop_plc_lost(stp[2]),
    .i_stop_plc_cmd(stp[3]), .i_zone_blocked(blk), .i_discharge(dis),
    .i_arrival(arr), .i_upstream_status_4(ups4),
    .i_cfg_left_speed(cfg_l), .i_cfg_right_speed(cfg_r),
    .o_rd_data(rd_data), .o_left_speed_ref(lref),
    .o_right_speed_ref(rref), .o_motor_run(run), .o_motor_rev(rev),
    .o_busy_upstream(busy), .o_accum_upstream(accu), .o_jam(jam),
    .o_indicator_flash(flash), .o_us_track_w1(us1),
    .o_us_track_w2(us2), .o_ds_track_w1(ds1), .o_ds_track_w2(ds2));

  always #50 i_ref_clk = ~i_ref_clk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] rnd();
    logic [31:0] r;
    r = $random(seed);
    return r[15:0];
  endfunction

  function automatic logic [31:0] trk(logic [31:0] old,
                                      logic [15:0] p, logic [15:0] q);
    if (p == 16'h0000 && q == 16'h0000)
      return old;
    if (p == 16'hffff && q == 16'hffff)
      return 32'h0000_0000;
    return {p, q};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic rchk(input logic [7:0] ad, input logic [15:0] e);
    logic [15:0] rv;
    plc.rd(ad, rv);
    plc.rd_end();
    chk(rv, e);
  endtask

  task automatic complete_run();
    if (err_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    seed    = 32'hb528;
    cfg_l   = rnd() | 16'h0001;
    cfg_r   = rnd() | 16'h0001;
    relv[0] = 16'h0000;
    relv[1] = 16'h0000;
    cur[0]  = 32'h0000_0000;
    cur[1]  = 32'h0000_0000;
    repeat (10) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    cyc(2);
    chk(lref, cfg_l);
    plc.wr(8'h40, 16'h0000);
    cyc(3);
    chk(rref, cfg_r);
    plc.wr(8'h28, 16'h0190);
    cyc(3);
    chk(lref, 16'h0190);
    plc.wr(8'h28, 16'h0000);
    cyc(3);
    chk(lref, 16'h0190);
    v = rnd() | 16'h0001;
    plc.wr(8'h40, v);
    cyc(3);
    chk(rref, v);
    for (k = 0; k < 8; k++)
    begin
      v = rnd();
      sraw = v[3:0];
      sinv = v[7:4];
      plc.rd(8'h23, d);
      plc.rd_end();
      a = sraw ^ sinv;
      chk(d & 16'h7fff, {9'h000, a[3], 1'b0, a[2], 1'b0, a[1], 1'b0,
          a[0]});
    end
    hb      = 1'bx;
    run_len = 16'h0000;
    toggles = 16'h0000;
    repeat (40)
    begin
      plc.rd(8'h23, d);
      if (d[15] !== hb)
      begin
        if (toggles > 16'h0001)
          chk(run_len, HB);
        toggles++;
        run_len = 16'h0000;
      end
      run_len++;
      hb = d[15];
    end
    plc.rd_end();
    chk({15'h0000, toggles > 16'h0003}, 16'h0001);
    for (k = 0; k < 16; k++)
    begin
      stp = k[3:0];
      plc.rd(8'h13, d);
      plc.rd_end();
      chk(d, {5'h00, stp[3], 2'b00, stp[2:0], 5'h00});
    end
    stp = 4'h0;
    plc.wr(8'h13, 16'hffff);
    rchk(8'h13, 16'h0000);
    rchk(8'h00, 16'h0000);
    for (z = 0; z < 2; z++)
    begin
      for (k = 0; k < 5; k++)
      begin
        plc.wr(z ? 8'hb8 : 8'h68, CT[k][19:4]);
        cyc(6);
        chk({12'h000, run[z], rev[z], busy[z], accu[z]},
            {12'h000, CT[k][3:0]});
      end
      hb = flash[z];
      cyc(4);
      chk({15'h0000, flash[z]}, {15'h0000, ~hb});
      plc.wr(z ? 8'hb8 : 8'h68, 16'h0000);
      ups4[z] = 1'b1;
      cyc(6);
      chk({15'h0000, run[z]}, 16'h0001);
      ups4[z] = 1'b0;
    end
    for (z = 0; z < 2; z++)
    begin
      plc.wr(z ? 8'hb8 : 8'h68, 16'h0001);
      blk[z] = 1'b1;
      cyc(6);
      for (k = 0; k < 5; k++)
      begin
        a = (k == 1) ? 16'h0000 : ((k == 2 || k == 3) ? 16'hffff : rnd());
        b = (k == 1) ? 16'h0000 : ((k > 2) ? 16'hffff : rnd());
        plc.wr(z ? 8'hd4 : 8'h84, a);
        plc.wr(z ? 8'hd5 : 8'h85, b);
        cyc(6);
        chk(z ? ds1 : us1, cur[z][31:16]);
        chk(z ? ds2 : us2, cur[z][15:0]);
        relv[z] = relv[z] + 16'h0001;
        plc.set_rel(z[0], relv[z]);
        cyc(8);
        cur[z] = trk(cur[z], a, b);
        chk(z ? ds1 : us1, cur[z][31:16]);
        chk(z ? ds2 : us2, cur[z][15:0]);
        dis[z] = 1'b1;
        cyc(1);
        dis[z] = 1'b0;
        blk[z] = 1'b0;
        cyc(3);
        arr[z] = 1'b1;
        cyc(1);
        arr[z] = 1'b0;
        blk[z] = 1'b1;
        cyc(6);
      end
      plc.set_rel(z[0], ~relv[z]);
      cyc(4);
      dis[z] = 1'b1;
      cyc(5);
      chk({15'h0000, jam[z]}, 16'h0001);
      plc.wr(z ? 8'hb8 : 8'h68, 16'h0201);
      cyc(4);
      chk({15'h0000, jam[z]}, 16'h0000);
      dis[z] = 1'b0;
    end
    for (k = 0; k < 8; k++)
    begin
      v = rnd();
      plc.wr(RW[k], v);
      rchk(RW[k], v);
    end
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    err_count++;
    complete_run();
  end
endmodule // testbench

// file: tb/zpio_bank_sva.sv
// Assertion checker for the zone PLC register bank
`timescale 1ns/100ps
module zpio_bank_sva
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_wr_en,
  input  wire logic [7:0]  i_wr_addr,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_rd_en,
  input  wire logic [7:0]  i_rd_addr,
  input  wire logic [15:0] i_release_us,
  input  wire logic [3:0]  i_sens_raw,
  input  wire logic [3:0]  i_sens_invert,
  input  wire logic        i_stop_group,
  input  wire logic        i_stop_comm_lost,
  input  wire logic        i_stop_plc_lost,
  input  wire logic        i_stop_plc_cmd,
  input  wire logic [15:0] o_rd_data,
  input  wire logic [15:0] o_left_speed_ref,
  input  wire logic [1:0]  o_motor_run,
  input  wire logic [1:0]  o_busy_upstream,
  input  wire logic [1:0]  o_accum_upstream,
  input  wire logic [15:0] o_us_track_w1,
  input  wire logic [15:0] o_us_track_w2
);
  // ------------------------------------------------------------
  // Shadow of the upstream control word and release age
  // ------------------------------------------------------------
  logic [15:0] acc_reg;
  logic [15:0] rel_reg;
  logic [3:0]  since_reg;
  logic [3:0]  sx;

  assign sx = i_sens_raw ^ i_sens_invert;

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      acc_reg   <= 16'h0000;
      rel_reg   <= 16'h0000;
      since_reg <= 4'hf;
    end
    else
    begin
      if (i_wr_en && i_wr_addr == zpio_pkg::OFS_US_ACCUM)
        acc_reg <= i_wr_data;
      rel_reg <= i_release_us;
      if (i_release_us != rel_reg)
        since_reg <= 4'h0;
      else if (since_reg != 4'hf)
        since_reg <= since_reg + 4'h1;
    end
  end

  function automatic logic [14:0] spread(logic [3:0] x);
    return {8'h00, x[3], 1'b0, x[2], 1'b0, x[1], 1'b0, x[0]};
  endfunction

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  property p_sensor;
    i_rd_en && i_rd_addr == zpio_pkg::OFS_SENSOR_INPUTS
      |=> o_rd_data[14:0] == spread($past(sx));
  endproperty
  a_sensor: assert property (p_sensor)
    else $error("sensor word wrong");

  property p_stop;
    i_rd_en && i_rd_addr == zpio_pkg::OFS_STOP_CAUSE
      |=> o_rd_data == {5'h00, $past(i_stop_plc_cmd), 2'b00,
          $past(i_stop_plc_lost), $past(i_stop_comm_lost),
          $past(i_stop_group), 5'h00};
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop word wrong");

  property p_speed_set;
    i_wr_en && i_wr_addr == zpio_pkg::OFS_LEFT_SPEED && i_wr_data != 0
      |-> ##3 o_left_speed_ref == $past(i_wr_data, 3);
  endproperty
  a_speed_set: assert property (p_speed_set)
    else $error("speed reference not taken");

  property p_speed_zero;
    i_wr_en && i_wr_addr == zpio_pkg::OFS_LEFT_SPEED && i_wr_data == 0
      |-> ##3 o_left_speed_ref == $past(o_left_speed_ref, 3);
  endproperty
  a_speed_zero: assert property (p_speed_zero)
    else $error("zero write changed speed");

  property p_track_cause;
    $changed(o_us_track_w1) || $changed(o_us_track_w2)
      |-> since_reg <= 4'h5;
  endproperty
  a_track_cause: assert property (p_track_cause)
    else $error("tracking changed without release");

  property p_maint_run;
    acc_reg[13] [*6] |-> !o_motor_run[0];
  endproperty
  a_maint_run: assert property (p_maint_run)
    else $error("motor runs in maintenance");

  property p_maint_busy;
    $rose(acc_reg[13]) |-> ##[1:6] o_busy_upstream[0];
  endproperty
  a_maint_busy: assert property (p_maint_busy)
    else $error("no busy in maintenance");

  property p_accum_up;
    acc_reg[8] [*6] |-> o_accum_upstream[0];
  endproperty
  a_accum_up: assert property (p_accum_up)
    else $error("upstream accumulate missing");
endmodule // zpio_bank_sva

bind zpio_bank zpio_bank_sva i_zpio_bank_sva (
  .i_ref_clk, .i_rst, .i_wr_en, .i_wr_addr, .i_wr_data, .i_rd_en,
  .i_rd_addr, .i_release_us, .i_sens_raw, .i_sens_invert,
  .i_stop_group, .i_stop_comm_lost, .i_stop_plc_lost, .i_stop_plc_cmd,
  .o_rd_data, .o_left_speed_ref, .o_motor_run, .o_busy_upstream,
  .o_accum_upstream, .o_us_track_w1, .o_us_track_w2
);

// file: tb/zpio_plc.sv
// PLC model: register access and release image words
`timescale 1ns/100ps
module zpio_plc
(
  input  wire logic        i_ref_clk,
  input  wire logic [15:0] i_rd_data,
  output logic             o_wr_en,
  output logic      [7:0]  o_wr_addr,
  output logic      [15:0] o_wr_data,
  output logic             o_rd_en,
  output logic      [7:0]  o_rd_addr,
  output logic      [15:0] o_rel_us,
  output logic      [15:0] o_rel_ds
);
  initial
  begin
    o_wr_en   = 1'b0;
    o_wr_addr = 8'h00;
    o_wr_data = 16'h0000;
    o_rd_en   = 1'b0;
    o_rd_addr = 8'h00;
    o_rel_us  = 16'h0000;
    o_rel_ds  = 16'h0000;
  end

  // Released lines are inverted so a stale value never matches
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    o_wr_en   = 1'b1;
    o_wr_addr = a;
    o_wr_data = d;
    @(posedge i_ref_clk);
    #1;
    o_wr_en   = 1'b0;
    o_wr_addr = ~a;
    o_wr_data = ~d;
    @(posedge i_ref_clk);
    #1;
  endtask

  // Strobe stays up so reads may run back to back
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    o_rd_en   = 1'b1;
    o_rd_addr = a;
    @(posedge i_ref_clk);
    #1;
    d = i_rd_data;
  endtask

  task automatic rd_end();
    o_rd_en   = 1'b0;
    o_rd_addr = ~o_rd_addr;
    @(posedge i_ref_clk);
    #1;
  endtask

  task automatic set_rel(input logic z, input logic [15:0] v);
    if (z)
      o_rel_ds = v;
    else
      o_rel_us = v;
  endtask
endmodule // zpio_plc
